// >>> bench/ltwc_mem_model.sv
/* Program memory model that keeps the word last programmed.
   Assumes the write strobe is synchronous to the clock. */
`timescale 1ns/1ps
`default_nettype none
module ltwc_mem_model (
    input  wire         clk_i,
    input  wire         we_i,
    input  wire  [15:0] addr_i,
    input  wire  [15:0] data_i,
    output logic [15:0] last_addr_o,
    output logic [15:0] last_data_o
);
    // The cell takes the word while the strobe is held.
    always @(posedge clk_i) begin
        if (we_i) begin
            last_addr_o <= addr_i;
            last_data_o <= data_i;
        end
    end
endmodule
`default_nettype wire

// >>> bench/ltwc_top_assertions.sv
/* Port checker for the long write controller.
   Assumes a bind onto ltwc_top and a single clock domain. */
`timescale 1ns/1ps
`default_nettype none
module ltwc_chk (
    input wire core_clk_i,
    input wire rst_n_i,
    input wire table_write_instruction_i,
    input wire clear_programming_voltage_pin_i,
    input wire external_interrupt_pin_i,
    input wire first_timer_overflow_i,
    input wire timer_clock_input_edge_i,
    input wire periph_flag_i,
    input wire psel,
    input wire stall_o,
    input wire prog_we_o,
    input wire vector_o,
    input wire nop_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);
    // High when nothing could end or alter a long write.
    wire quiet = !external_interrupt_pin_i && !first_timer_overflow_i &&
        !timer_clock_input_edge_i && !periph_flag_i && !psel;
    chk_we_stall: assert property (prog_we_o |-> stall_o)
        else $error("write without stall");
    chk_we_start: assert property (
        $rose(prog_we_o) |-> $past(table_write_instruction_i))
        else $error("write began uncommanded");
    chk_quiet_hold: assert property (
        (prog_we_o && quiet) [*3] |=> prog_we_o)
        else $error("write ended without cause");
    chk_short_nowe: assert property (
        table_write_instruction_i && !clear_programming_voltage_pin_i
        && !stall_o |=> !prog_we_o [*2])
        else $error("array written without voltage");
    chk_short_len: assert property (
        $rose(stall_o) && !prog_we_o |-> stall_o [*2] ##1 !stall_o)
        else $error("short write length wrong");
    chk_vec_pulse: assert property (vector_o |=> !vector_o)
        else $error("vector pulse too long");
    chk_vec_free: assert property (vector_o |-> !stall_o)
        else $error("vector during write");
    chk_nop_cause: assert property (
        nop_o |-> $past(table_write_instruction_i) && !prog_we_o)
        else $error("stray abort");
endmodule
`default_nettype wire

// >>> bench/testbench.sv
/* Self-checking bench for the long write controller.
   Assumes the checker and memory model are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        clk = 0, rst_n = 0, tw = 0, volt = 0, ext = 0, tm0 = 0;
    logic        tck = 0, per = 0, ret = 0, psel = 0, pen = 0, pwr = 0;
    logic [11:0] pa = '0;
    logic [31:0] pwd = '0, r;
    logic [15:0] ta = '0, td = '0, a, d;
    wire         prdy, perr, stall, we, vec, nop, irq;
    wire  [31:0] prd;
    wire  [15:0] pad, pdt, ma, md;
    wire  [1:0]  vsel;
    int          err_count = 0, samples_checked = 0, n, src;

    ltwc_top dut (
        .core_clk_i(clk), .rst_n_i(rst_n), .table_write_instruction_i(tw),
        .tbl_addr_i(ta), .tbl_data_i(td),
        .clear_programming_voltage_pin_i(volt),
        .external_interrupt_pin_i(ext), .first_timer_overflow_i(tm0),
        .timer_clock_input_edge_i(tck), .periph_flag_i(per),
        .irq_return_i(ret),
        .psel(psel), .penable(pen), .pwrite(pwr), .paddr(pa), .pwdata(pwd),
        .pready(prdy), .prdata(prd), .pslverr(perr), .stall_o(stall),
        .prog_we_o(we), .prog_addr_o(pad), .prog_data_o(pdt),
        .vector_o(vec), .vector_sel_o(vsel), .nop_o(nop), .irq_o(irq));
    ltwc_mem_model mem (.clk_i(clk), .we_i(we), .addr_i(pad),
        .data_i(pdt), .last_addr_o(ma), .last_data_o(md));

    // Free-running 125 MHz clock.
    initial forever #4 clk = ~clk;

    // Compares a value and counts the outcome.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // One APB transfer, held until pready is seen high.
    task automatic apb(input logic w, input logic [11:0] ad,
                       input logic [31:0] wd);
        psel <= 1; pwr <= w; pa <= ad; pwd <= wd;
        @(posedge clk) pen <= 1;
        do @(posedge clk); while (prdy !== 1'b1);
        r = prd;
        psel <= 0; pen <= 0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [11:0] ad, input logic [31:0] wd);
        apb(1, ad, wd);
    endtask
    task automatic rd(input logic [11:0] ad, input logic [31:0] exp);
        apb(0, ad, '0);
        chk(r, exp);
        chk({prdy, perr}, 2);
    endtask
    task automatic pulse_tw(input logic [15:0] pa_, input logic [15:0] pd_);
        ta <= pa_; td <= pd_; tw <= 1;
        @(posedge clk) tw <= 0;
    endtask

    // Prints the verdict and ends the run.
    task automatic print_verdict();
        if (err_count == 0 && samples_checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    // Main sequence: every source with the global disable both ways.
    initial begin
        void'($urandom(32'h0720D6F8));
        repeat (10) @(posedge clk);
        rst_n <= 1;
        @(posedge clk);
        rd(12'h000, 1);
        rd(12'h020, 0);
        wr(12'h014, 15);
        for (int s = 0; s < 8; s++) begin
            src = s % 4;
            wr(12'h000, s / 4);
            wr(12'h004, 1 << src);
            volt <= 1;
            a = $urandom;
            d = $urandom;
            pulse_tw(a, d);
            repeat ($urandom_range(2, 12)) @(posedge clk);
            chk(we && stall, 1);
            if (src < 3) {tck, tm0, ext} <= 3'h1 << src;
            else per <= 1;
            @(posedge clk) {tck, tm0, ext} <= '0;
            n = 0;
            while (stall === 1'b1 && n < 9) begin
                @(posedge clk);
                n++;
            end
            chk({stall, vec}, s < 4);
            if (s < 4) chk(vsel, src);
            chk({ma, md}, {a, d});
            rd(12'h008, src == 3 ? 8 : 0);
            rd(12'h000, 1);
            rd(12'h010, s < 4 ? 9 : 1);
            chk(irq, 1);
            wr(12'h010, 15);
            per <= 0;
            ret <= 1;
            @(posedge clk) ret <= 0;
            rd(12'h000, 0);
        end
        // A pending pair aborts the write; only the higher flag clears.
        wr(12'h000, 1);
        wr(12'h004, 3);
        {tm0, ext} <= 2'h3;
        @(posedge clk) {tm0, ext} <= '0;
        @(posedge clk);
        pulse_tw(a, d);
        @(posedge clk);
        chk({nop, we}, 2);
        rd(12'h008, 2);
        rd(12'h010, 2);
        wr(12'h014, 0);
        chk(irq, 0);
        wr(12'h014, 2);
        chk(irq, 1);
        wr(12'h010, 2);
        chk(irq, 0);
        wr(12'h008, 2);
        // Without the programming voltage the array keeps its word.
        volt <= 0;
        pulse_tw(~a, ~d);
        repeat (4) @(posedge clk);
        chk({we, stall}, 0);
        chk({ma, md}, {a, d});
        rd(12'h010, 4);
        // A disabled source cannot end the write; reset does.
        volt <= 1;
        wr(12'h004, 2);
        pulse_tw(a, d);
        ext <= 1;
        @(posedge clk) ext <= 0;
        repeat (4) @(posedge clk);
        chk(stall, 1);
        rd(12'h008, 1);
        rst_n <= 0;
        repeat (2) @(posedge clk);
        chk(we, 0);
        rst_n <= 1;
        @(posedge clk);
        rd(12'h000, 1);
        print_verdict();
    end

    // Cuts a hung run short.
    initial begin
        #200us;
        err_count++;
        print_verdict();
    end
endmodule

bind ltwc_top ltwc_chk u_chk (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .table_write_instruction_i(table_write_instruction_i),
    .clear_programming_voltage_pin_i(clear_programming_voltage_pin_i),
    .external_interrupt_pin_i(external_interrupt_pin_i),
    .first_timer_overflow_i(first_timer_overflow_i),
    .timer_clock_input_edge_i(timer_clock_input_edge_i),
    .periph_flag_i(periph_flag_i), .psel(psel), .stall_o(stall_o),
    .prog_we_o(prog_we_o), .vector_o(vector_o), .nop_o(nop_o));
`default_nettype wire

// >>> include/ltwc_defines.vh
/*
 * Constants for the long table write controller: register offsets,
 * field positions, reset values and timing counts.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef LTWC_DEFINES_VH
`define LTWC_DEFINES_VH

// Register byte offsets on the APB slave.
`define LTWC_OFS_CTRL        12'h000
`define LTWC_OFS_ENABLE      12'h004
`define LTWC_OFS_FLAG        12'h008
`define LTWC_OFS_STATUS      12'h00C
`define LTWC_OFS_IRQ_STAT    12'h010
`define LTWC_OFS_IRQ_MASK    12'h014

// Control register fields.
`define LTWC_CTRL_GDIS_BIT   0
`define LTWC_CTRL_RST        1'h1

// Source indices; lower index has higher priority among core sources.
`define LTWC_SRC_EXT         0
`define LTWC_SRC_TMR         1
`define LTWC_SRC_TCKI        2
`define LTWC_SRC_PERI        3
`define LTWC_NUM_SRC         4

// Event status bits.
`define LTWC_EV_DONE_BIT     0
`define LTWC_EV_ABORT_BIT    1
`define LTWC_EV_SHORT_BIT    2
`define LTWC_EV_VECT_BIT     3
`define LTWC_NUM_EV          4

// Short write length in cycles when the programming voltage is absent.
`define LTWC_SHORT_CYCLES    2'h2

`endif

// >>> rtl/ltwc_prio.v
/*
 * Priority picker: one-hot grant of the lowest-index set request.
 * Assumes a purely combinational use inside the controller.
 */
`timescale 1ns/1ps
`default_nettype none

module ltwc_prio #(
    parameter N = 3
) (
    input  wire [N-1:0] req_i,
    output reg  [N-1:0] gnt_o
);

    integer i;
    reg     found;

    // Walk from the highest priority bit upward and grant the first.
    always @* begin
        gnt_o = {N{1'b0}};
        found = 1'b0;
        for (i = 0; i < N; i = i + 1) begin
            if (req_i[i] && !found) begin
                gnt_o[i] = 1'b1;
                found = 1'b1;
            end
        end
    end

endmodule

`default_nettype wire

// >>> rtl/ltwc_top.v
/*
 * Long table write controller: stalls the core during a long write to
 * program memory, ends it on a qualifying interrupt or on reset, and
 * decides vectoring and automatic flag clearing.
 * Offsets, field positions and the short write length are shared constants.
 * Assumes a single 125 MHz clock, synchronous inputs, and an APB master.
 */
// Notes on behaviour
// - Table write starts long write, stalls core
// - Only qualifying interrupt or reset ends it
// - Enable and flag end it; global ignored
// - Vector when global disable clear, else continue
// - Core source: highest enabled flag auto-cleared
// - Pending interrupt aborts write as no-op
// - Peripheral flag stays set on vectoring
// - Core source, disabled globally: end, clear
// - Peripheral, disabled globally: end, keep flag
// - No programming voltage: two-cycle write, unchanged
// - Vectoring sets global disable
// - Flags set regardless of enable and global
`timescale 1ns/1ps
`default_nettype none
`include "ltwc_defines.vh"

module ltwc_top #(
    // Table address and data widths of the program memory.
    parameter AW = 16,
    parameter DW = 16
) (
    input  wire          core_clk_i,
    input  wire          rst_n_i,
    // Core table write request, interrupt sources and return.
    input  wire          table_write_instruction_i,
    input  wire [AW-1:0] tbl_addr_i,
    input  wire [DW-1:0] tbl_data_i,
    input  wire          clear_programming_voltage_pin_i,
    input  wire          external_interrupt_pin_i,
    input  wire          first_timer_overflow_i,
    input  wire          timer_clock_input_edge_i,
    input  wire          periph_flag_i,
    input  wire          irq_return_i,
    // APB register port.
    input  wire          psel,
    input  wire          penable,
    input  wire          pwrite,
    input  wire [11:0]   paddr,
    input  wire [31:0]   pwdata,
    output wire          pready,
    output reg  [31:0]   prdata,
    output wire          pslverr,
    // Core and program memory side.
    output wire          stall_o,
    output reg           prog_we_o,
    output reg  [AW-1:0] prog_addr_o,
    output reg  [DW-1:0] prog_data_o,
    output reg           vector_o,
    output reg  [1:0]    vector_sel_o,
    output reg           nop_o,
    output wire          irq_o
);

    // Sequencer states. Idle accepts a table write; the long state holds
    // the array strobe until a qualifying source or reset; the short
    // state models the two-cycle write taken when the programming
    // voltage is missing, during which the array is never touched.
    localparam ST_IDLE  = 2'h0;
    localparam ST_LONG  = 2'h1;
    localparam ST_SHORT = 2'h2;

    // Three core sources plus one summary line for all peripherals.
    localparam NS = `LTWC_NUM_SRC;

    // Sequencer state, software-visible control and event bookkeeping.
    reg  [1:0]    state;
    reg  [1:0]    short_cnt;
    reg           global_interrupt_disable;
    reg  [NS-1:0] enable;
    reg  [2:0]    core_flag;
    reg  [`LTWC_NUM_EV-1:0] ev_stat;
    reg  [`LTWC_NUM_EV-1:0] ev_mask;

    // Source qualification and bus decode; all of it is combinational
    // and settles within the cycle in which the inputs are sampled.
    wire [2:0]    core_evt;
    wire [2:0]    core_qual;
    wire [2:0]    core_gnt;
    wire          peri_qual;
    wire          any_qual;
    wire          apb_acc;
    wire          apb_wr;
    wire          apb_rd;
    // Outcome of the current cycle, decided once and used by the sequencer,
    // flag, global disable and event registers so that they can never disagree.
    reg  [2:0]    next_core_clr;
    reg           next_vec;
    reg           next_done;
    reg           next_abort;
    reg           next_short;
    reg  [1:0]    next_sel;

    // Event pulses in priority order: bit 0 is the external pin, bit 2
    // the timer clock input edge.
    assign core_evt = {timer_clock_input_edge_i, first_timer_overflow_i,
                       external_interrupt_pin_i};

    // A source qualifies with both enable and flag set; global not used.
    assign core_qual = core_flag & enable[2:0];
    assign peri_qual = periph_flag_i & enable[`LTWC_SRC_PERI];
    assign any_qual  = (|core_qual) | peri_qual;

    // Highest-priority enabled pending core source. The grant is one-hot,
    // so an abort or a termination clears at most one core flag and the
    // lower ones stay pending for the core to take later.
    ltwc_prio #(
        .N(3)
    ) u_prio (
        .req_i (core_qual),
        .gnt_o (core_gnt)
    );

    // APB slave handshake: zero wait state, no errors. Read data is
    // prepared in the setup cycle, so the access cycle can always end
    // at once; unmapped offsets read as zero and ignore writes.
    assign pready  = 1'b1;
    assign pslverr = 1'b0;
    assign apb_acc = psel & penable;
    assign apb_wr  = apb_acc & pwrite;
    assign apb_rd  = apb_acc & ~pwrite;

    // Core stalls during long write and during the short write. The
    // stall follows the state directly, so it drops in the same cycle
    // as the array strobe and the core never runs with the strobe high.
    assign stall_o = (state == ST_LONG) || (state == ST_SHORT);

    // One level interrupt: high while any unmasked event bit is set.
    // Masking hides an event from the line but keeps it in the status.
    assign irq_o = |(ev_stat & ev_mask);

    // Decide the outcome of this cycle from state and sources. The
    // global disable only chooses between vectoring and resuming; it is
    // deliberately left out of the qualification, so a write still ends
    // while interrupts are globally off. Peripheral flags belong to
    // their owners and are never cleared here.
    always @* begin
        next_core_clr = 3'h0;
        next_vec      = 1'b0;
        next_done     = 1'b0;
        next_abort    = 1'b0;
        next_short    = 1'b0;
        next_sel      = 2'h0;
        case (state)
            ST_IDLE: begin
                if (table_write_instruction_i && any_qual) begin
                    // Pending interrupt turns the write into a no-op.
                    next_abort    = 1'b1;
                    next_core_clr = core_gnt;
                end else if (table_write_instruction_i &&
                             !clear_programming_voltage_pin_i) begin
                    next_short = 1'b1;
                end
            end
            // A table write seen here is ignored: the core is stalled and
            // cannot issue one, and a second strobe would upset the cell.
            ST_LONG: begin
                if (any_qual) begin
                    // Only a qualifying source ends the write.
                    next_done = 1'b1;
                    next_vec  = ~global_interrupt_disable;
                    if (|core_qual) begin
                        // Core flag cleared whether vectoring or not.
                        next_core_clr = core_gnt;
                        next_sel = core_gnt[0] ? 2'h0 :
                                   (core_gnt[1] ? 2'h1 : 2'h2);
                    end else begin
                        // Peripheral flag untouched here.
                        next_sel = 2'h3;
                    end
                end
            end
            // The short state and any unused code decide nothing.
            default: begin
                next_done = 1'b0;
            end
        endcase
    end

    // Write sequencer, program memory strobe and core indications.
    // Address and data are captured with the pulse and held for the
    // whole long write, since the core may change its buses while it
    // is stalled. Vector and abort indications last one cycle. A reset
    // in the middle of a long write drops the strobe at once.
    always @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            state        <= ST_IDLE;
            short_cnt    <= 2'h0;
            prog_we_o    <= 1'b0;
            prog_addr_o  <= {AW{1'b0}};
            prog_data_o  <= {DW{1'b0}};
            vector_o     <= 1'b0;
            vector_sel_o <= 2'h0;
            nop_o        <= 1'b0;
        end else begin
            vector_o <= next_vec;
            nop_o    <= next_abort;
            if (next_vec) begin
                vector_sel_o <= next_sel;
            end
            case (state)
                ST_IDLE: begin
                    if (next_short) begin
                        // Short write never drives the array.
                        state     <= ST_SHORT;
                        short_cnt <= `LTWC_SHORT_CYCLES - 2'h1;
                    end else if (table_write_instruction_i &&
                                 !next_abort) begin
                        // An abort leaves the sequencer idle, so the
                        // array is never strobed for that write.
                        state       <= ST_LONG;
                        prog_we_o   <= 1'b1;
                        prog_addr_o <= tbl_addr_i;
                        prog_data_o <= tbl_data_i;
                    end
                end
                ST_LONG: begin
                    if (next_done) begin
                        // Release the write before resuming.
                        state     <= ST_IDLE;
                        prog_we_o <= 1'b0;
                    end
                end
                ST_SHORT: begin
                    // Counts down from one less than the short length, so
                    // the stall lasts exactly the short write's cycles.
                    if (short_cnt == 2'h0) begin
                        state <= ST_IDLE;
                    end
                    short_cnt <= short_cnt - 2'h1;
                end
                // An unused code recovers to idle with the strobe released.
                default: begin
                    state     <= ST_IDLE;
                    prog_we_o <= 1'b0;
                end
            endcase
        end
    end

    // Core flags: events set, auto clear and software clear; set wins.
    // A flag is set whatever its enable and the global disable say, so
    // a new event in the clearing cycle is kept rather than lost.
    // Source index g matches the bit of the flag register.
    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1) begin : g_flag
            always @(posedge core_clk_i) begin
                if (!rst_n_i) begin
                    core_flag[g] <= 1'b0;
                end else if (core_evt[g]) begin
                    core_flag[g] <= 1'b1;
                end else if (next_core_clr[g]) begin
                    core_flag[g] <= 1'b0;
                end else if (apb_wr && paddr == `LTWC_OFS_FLAG &&
                             pwdata[g]) begin
                    core_flag[g] <= 1'b0;
                end
            end
        end
    endgenerate

    // Global disable: set on vectoring, cleared by return or software.
    // It comes out of reset set, so nothing vectors before software has
    // prepared the handlers. Vectoring wins over a return in one cycle.
    // Software may also write it directly.
    always @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            global_interrupt_disable <= `LTWC_CTRL_RST;
        end else if (next_vec) begin
            global_interrupt_disable <= 1'b1;
        end else if (irq_return_i) begin
            global_interrupt_disable <= 1'b0;
        end else if (apb_wr && paddr == `LTWC_OFS_CTRL) begin
            global_interrupt_disable <= pwdata[`LTWC_CTRL_GDIS_BIT];
        end
    end

    // Enable and event mask registers. An enable written while a flag
    // is already set makes that source qualify in the next cycle.
    always @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            enable  <= {NS{1'b0}};
            ev_mask <= {`LTWC_NUM_EV{1'b0}};
        end else if (apb_wr) begin
            if (paddr == `LTWC_OFS_ENABLE) begin
                enable <= pwdata[NS-1:0];
            end
            if (paddr == `LTWC_OFS_IRQ_MASK) begin
                ev_mask <= pwdata[`LTWC_NUM_EV-1:0];
            end
        end
    end

    // Sticky event bits, write one to clear; a new event wins.
    // Bit order is done, abort, short, vector, so one write of all ones
    // clears every event seen so far without a read first.
    always @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            ev_stat <= {`LTWC_NUM_EV{1'b0}};
        end else begin
            ev_stat <= (ev_stat &
                        ~((apb_wr && paddr == `LTWC_OFS_IRQ_STAT) ?
                          pwdata[`LTWC_NUM_EV-1:0] :
                          {`LTWC_NUM_EV{1'b0}})) |
                       {next_vec, next_short, next_abort, next_done};
        end
    end

    // Read data is registered during the setup phase of a read and
    // holds until the next read setup, so flops drive the bus.
    always @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                `LTWC_OFS_CTRL:
                    prdata <= {31'h0, global_interrupt_disable};
                `LTWC_OFS_ENABLE:
                    prdata <= {{(32-NS){1'b0}}, enable};
                `LTWC_OFS_FLAG:
                    prdata <= {28'h0, periph_flag_i, core_flag};
                `LTWC_OFS_STATUS:
                    prdata <= {29'h0, prog_we_o, state};
                `LTWC_OFS_IRQ_STAT:
                    prdata <= {28'h0, ev_stat};
                `LTWC_OFS_IRQ_MASK:
                    prdata <= {28'h0, ev_mask};
                default:
                    prdata <= 32'h0000_0000;
            endcase
        end
    end

endmodule

`default_nettype wire
